// ---- bench/tcs_partner.sv ----
// downstream receiver model issuing credit grants
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // grant request, slow adds a cycle
  input wire logic reqValid,
  input wire logic slow,
  input wire logic [`TCS_PORT_W-1:0] reqPort,
  input wire logic [`TCS_CREDIT_W-1:0] reqBytes,
  // status update
  output var tcs_pkg::tcs_grant_t grant
);
  tcs_pkg::tcs_grant_t stage, next_stage, next_grant;
  // prompt grants skip the extra stage
  always_comb begin
    next_stage = reqValid ? tcs_pkg::tcs_grant_t'{1'b1, reqPort, reqBytes} : '0;
    next_grant = slow ? stage : next_stage;
  end
  // one-cycle grant pulses
  always_ff @(posedge clk_sys) begin
    stage <= rst ? '0 : next_stage;
    grant <= rst ? '0 : next_grant;
  end
endmodule
`default_nettype wire

// ---- bench/tcs_scheduler_asserts.sv ----
// port assertions of the scheduler
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_scheduler_asserts #(parameter int BurstBytes = 64) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // scheduler
  input wire logic [1:0] switchMode,
  input wire logic [`TCS_NPORTS-1:0][`TCS_LEVEL_W-1:0] bufLevel,
  input wire logic statusDisableReq,
  input wire tcs_pkg::tcs_beat_t beat,
  input wire logic txEnable,
  input wire logic [`TCS_PORT_W-1:0] txPort
);
  logic [`TCS_NPORTS-1:0][`TCS_LEVEL_W-1:0] lvlPrev;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // levels one cycle back
  always_ff @(posedge clk_sys) lvlPrev <= bufLevel;
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  reset_val_a: assert property ($fell(rst) |-> !txEnable && !pready && statusDisableReq)
    else $error("bad reset state");
  port_hold_a: assert property (txEnable && $past(txEnable) |-> $stable(txPort))
    else $error("port changed in service");
  port_elig_a: assert property ($rose(txEnable) |-> lvlPrev[txPort] >= BurstBytes)
    else $error("port picked without data");
  eop_leave_a: assert property (switchMode != 2'h0 && txEnable && beat.valid && beat.eop
    |=> !txEnable)
    else $error("no switch on end of packet");
endmodule
`default_nettype wire

// ---- bench/tcs_scheduler_tb.sv ----
// self-checking bench of the scheduler
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_scheduler_tb;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, statusDisableReq, txEnable, err;
  logic [1:0] switchMode = 2'h0, calSelWord = 2'h0;
  logic statSync = 1'b1, statDisabled = 1'b1, reqValid = 1'b0, slow = 1'b0;
  logic [3:0] reqPort = '0, txPort;
  logic [15:0] reqBytes = '0;
  logic [`TCS_NPORTS-1:0][`TCS_LEVEL_W-1:0] bufLevel = '0;
  logic [7:0] activeMultiplier;
  logic [9:0] activeLength;
  tcs_pkg::tcs_grant_t grant;
  tcs_pkg::tcs_beat_t beat = '0;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  tcs_scheduler u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switchMode(switchMode), .grant(grant), .bufLevel(bufLevel),
    .statSync(statSync), .statDisabled(statDisabled), .calSelWord(calSelWord),
    .statusDisableReq(statusDisableReq), .activeMultiplier(activeMultiplier),
    .activeLength(activeLength), .beat(beat), .txEnable(txEnable), .txPort(txPort));
  tcs_partner u_partner (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .slow(slow),
    .reqPort(reqPort), .reqBytes(reqBytes), .grant(grant));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_sys);
    rst <= 1'b1;
    switchMode <= m;
    bufLevel <= '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // credit grant to port 3
  task automatic give(input logic [15:0] b, input logic s);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqPort <= 4'h3;
    reqBytes <= b;
    slow <= s;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // 16-byte beats, then check whether service goes on
  task automatic beats(input int n, input logic e, input logic exp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      beat <= '{1'b1, 6'h10, e && i == n - 1};
    end
    @(posedge clk_sys);
    beat <= '0;
    #1 chk("txEnable", txEnable, exp);
  endtask
  // wait for service of port 3 and check its credits
  task automatic serve(input logic [15:0] cred);
    int i;
    i = 0;
    while (txEnable !== 1'b1 && i < 20) begin
      @(posedge clk_sys);
      i++;
    end
    apb(1'b0, `TCS_ADDR(`TCS_IDX_SCHED), 32'h0);
    chk("sched", rd, 32'h0103_0000 | cred);
  endtask
  task automatic test_regs();
    apb(1'b0, `TCS_ADDR(`TCS_IDX_CTRL), 32'h0);
    chk("ctrl reset", rd, 32'h32);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_BURST), 32'h0);
    chk("burst reset", rd, 32'h40);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_BURST), 32'h200);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_BURST), 32'h0);
    chk("burst rw", rd, 32'h200);
    apb(1'b0, 12'h03C, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_MULT_B), 32'h5A);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_MULT_B), 32'h0);
    chk("reserved b", rd, 32'h0);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_MULT_A), 32'h11);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_LEN_A), 32'h155);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_CAL_ADR), 32'h2A5);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_DATA_A), 32'hC3);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_DATA_A), 32'h0);
    chk("cal a data", rd, 32'hC3);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_CTRL), 32'h1);
    #1 chk("disable req", statusDisableReq, 1'b0);
    // the write made while reserved must not have landed
    apb(1'b0, `TCS_ADDR(`TCS_IDX_MULT_B), 32'h0);
    chk("dropped b", rd, 32'h0);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_MULT_B), 32'h5A);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_MULT_B), 32'h0);
    chk("mult b", rd, 32'h5A);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_LEN_B), 32'h2AA);
    apb(1'b1, `TCS_ADDR(`TCS_IDX_DATA_B), 32'h3C);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_DATA_B), 32'h0);
    chk("cal b data", rd, 32'h3C);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_DATA_A), 32'h0);
    chk("cal a kept", rd, 32'hC3);
    statDisabled <= 1'b0;
    calSelWord <= 2'h1;
    repeat (4) @(posedge clk_sys);
    chk("mult a active", activeMultiplier, 8'h11);
    chk("len a active", activeLength, 10'h155);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_CTRL), 32'h0);
    chk("ctrl a", rd, 32'h11);
    calSelWord <= 2'h2;
    repeat (4) @(posedge clk_sys);
    chk("mult b active", activeMultiplier, 8'h5A);
    chk("len b active", activeLength, 10'h2AA);
    apb(1'b0, `TCS_ADDR(`TCS_IDX_CTRL), 32'h0);
    chk("ctrl b", rd, 32'h19);
    $display("test_regs done");
  endtask
  task automatic test_sched(input logic [1:0] m);
    do_reset(m);
    bufLevel[3] <= 12'h0C8;
    give(16'h20, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk("idle", txEnable, 1'b0);
    give(16'h20, 1'b1);
    serve(16'h40);
    give(16'hC0, 1'b0);
    serve(16'h40);
    beats(4, 1'b0, 1'b0);
    serve(16'hC0);
    beats(1, 1'b1, m == 2'h0);
    serve(16'hB0);
    beats(4, 1'b0, !m[1]);
    serve(16'h70);
    // short buffer ends service at the packet end even in mode 00
    bufLevel[3] <= 12'h030;
    beats(1, 1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk("no data", txEnable, 1'b0);
    $display("test_sched mode %0d done", m);
  endtask
  initial begin
    do_reset(2'h0);
    test_regs();
    for (int m = 0; m < 4; m++) test_sched(2'(m));
    end_sim();
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
endmodule
bind tcs_scheduler tcs_scheduler_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .switchMode(switchMode), .bufLevel(bufLevel), .statusDisableReq(statusDisableReq),
  .beat(beat), .txEnable(txEnable), .txPort(txPort));
`default_nettype wire

// ---- core/tcs_params.svh ----
// constants of the transmit credit port scheduler
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
`define TCS_NPORTS 16
`define TCS_PORT_W 4
`define TCS_CREDIT_W 16
`define TCS_LEVEL_W 12
`define TCS_BEAT_W 6
`define TCS_BURST_W 11
`define TCS_CAL_DEPTH 1024
`define TCS_CAL_ADR_W 10
`define TCS_ADDR_W 12
// register indices, byte address is index times four
`define TCS_IDX_CTRL 1
`define TCS_IDX_MULT_A 2
`define TCS_IDX_MULT_B 3
`define TCS_IDX_LEN_A 4
`define TCS_IDX_LEN_B 5
`define TCS_IDX_CAL_ADR 6
`define TCS_IDX_DATA_A 7
`define TCS_IDX_DATA_B 8
`define TCS_IDX_BURST 16
`define TCS_IDX_SCHED 17
`define TCS_ADDR(i) (12'(i) << 2)
// control register fields
`define TCS_CTRL_HITLESS 0
`define TCS_CTRL_DISREQ 1
`define TCS_CTRL_ACTSEL 3
`define TCS_CTRL_SYNC 4
`define TCS_CTRL_DISABLED 5
// reset values
`define TCS_BURST_RST 10'h040
`define TCS_DISREQ_RST 1'b1
// received calendar select words
`define TCS_CALWORD_A 2'h1
`define TCS_CALWORD_B 2'h2
// switching modes
`define TCS_MODE_NOEOP 2'h0
`define TCS_MODE_EOP 2'h1
`endif

// ---- core/tcs_pkg.sv ----
// types of the transmit credit port scheduler
`include "tcs_params.svh"
package tcs_pkg;
  typedef struct packed {
    logic valid;
    logic [`TCS_PORT_W-1:0] port;
    logic [`TCS_CREDIT_W-1:0] bytes;
  } tcs_grant_t;
  typedef struct packed {
    logic valid;
    logic [`TCS_BEAT_W-1:0] bytes;
    logic eop;
  } tcs_beat_t;
  typedef enum logic [0:0] {TCS_IDLE, TCS_SERVE} tcs_state_t;
endpackage

// ---- core/tcs_port_credit.sv ----
// next-credit entry of one port
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_port_credit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // credit granted by a status update
  input wire logic grantValid,
  input wire logic [`TCS_CREDIT_W-1:0] grantBytes,
  // credit spent by transmitted bytes
  input wire logic spendValid,
  input wire logic [`TCS_BEAT_W-1:0] spendBytes,
  // present credit
  output logic [`TCS_CREDIT_W-1:0] credit
);
  logic [`TCS_CREDIT_W-1:0] next_credit;
  logic [`TCS_CREDIT_W:0] sum;

  // saturating add of grants, floor at zero on spending
  always_comb begin
    sum = {1'b0, credit};
    if (grantValid) begin
      sum = sum + {1'b0, grantBytes};
    end
    if (spendValid) begin
      if (sum > (`TCS_CREDIT_W+1)'(spendBytes)) begin
        sum = sum - (`TCS_CREDIT_W+1)'(spendBytes);
      end else begin
        sum = '0;
      end
    end
    next_credit = sum[`TCS_CREDIT_W] ? '1 : sum[`TCS_CREDIT_W-1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      credit <= '0;
    end else begin
      credit <= next_credit;
    end
  end
endmodule
`default_nettype wire

// ---- core/tcs_scheduler.sv ----
// transmit credit port scheduler with apb calendar registers
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_scheduler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TCS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // static switching mode
  input wire logic [1:0] switchMode,
  // credit status and buffer levels
  input wire tcs_pkg::tcs_grant_t grant,
  input wire logic [`TCS_NPORTS-1:0][`TCS_LEVEL_W-1:0] bufLevel,
  // status machine view
  input wire logic statSync,
  input wire logic statDisabled,
  input wire logic [1:0] calSelWord,
  output logic statusDisableReq,
  output logic [7:0] activeMultiplier,
  output logic [`TCS_CAL_ADR_W-1:0] activeLength,
  // transmit path
  input wire tcs_pkg::tcs_beat_t beat,
  output logic txEnable,
  output logic [`TCS_PORT_W-1:0] txPort
);
  logic [7:0] calA [`TCS_CAL_DEPTH];
  logic [7:0] calB [`TCS_CAL_DEPTH];
  logic [`TCS_NPORTS-1:0][`TCS_CREDIT_W-1:0] nextCredit;
  logic hitless, activeSel, next_activeSel;
  logic [7:0] multA, multB;
  logic [`TCS_CAL_ADR_W-1:0] lenA, lenB, calAdr;
  logic [9:0] burstReg;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, wrEn;
  logic [`TCS_ADDR_W-1:0] idx;
  tcs_pkg::tcs_state_t state, next_state;
  logic [`TCS_CREDIT_W-1:0] curCredit, next_curCredit;
  logic [`TCS_BURST_W-1:0] sentCount, next_sentCount, burstBytes;
  logic [`TCS_PORT_W-1:0] next_txPort, lastPort, next_lastPort;
  logic next_txEnable;

  // refused accesses never write, unaligned ones included
  assign wrEn = psel & penable & pready & pwrite & ~pslverr;
  assign idx = paddr >> 2;
  // burst field 0 stands for 1024 bytes
  assign burstBytes = {burstReg == 10'h000, burstReg};

  // per-port next-credit table
  genvar g;
  generate
    for (g = 0; g < `TCS_NPORTS; g++) begin : gCredit
      tcs_port_credit uCredit (
        .clk_sys(clk_sys),
        .rst(rst),
        .grantValid(grant.valid && grant.port == `TCS_PORT_W'(g)),
        .grantBytes(grant.bytes),
        .spendValid(txEnable && beat.valid && txPort == `TCS_PORT_W'(g)),
        .spendBytes(beat.bytes),
        .credit(nextCredit[g])
      );
    end
  endgenerate

  // apb answer, one wait state, read data captured at the answer
  always_comb begin
    next_pready = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata = '0;
    if (psel & penable & ~pready) begin
      case (paddr)
        `TCS_ADDR(`TCS_IDX_CTRL): begin
          next_prdata[`TCS_CTRL_HITLESS] = hitless;
          next_prdata[`TCS_CTRL_DISREQ] = statusDisableReq;
          next_prdata[`TCS_CTRL_ACTSEL] = activeSel;
          next_prdata[`TCS_CTRL_SYNC] = statSync;
          next_prdata[`TCS_CTRL_DISABLED] = statDisabled;
        end
        `TCS_ADDR(`TCS_IDX_MULT_A): next_prdata[7:0] = multA;
        `TCS_ADDR(`TCS_IDX_MULT_B): next_prdata[7:0] = hitless ? multB : 8'h00;
        `TCS_ADDR(`TCS_IDX_LEN_A): next_prdata[9:0] = lenA;
        `TCS_ADDR(`TCS_IDX_LEN_B): next_prdata[9:0] = hitless ? lenB : 10'h000;
        `TCS_ADDR(`TCS_IDX_CAL_ADR): next_prdata[9:0] = calAdr;
        `TCS_ADDR(`TCS_IDX_DATA_A): next_prdata[7:0] = calA[calAdr];
        `TCS_ADDR(`TCS_IDX_DATA_B): next_prdata[7:0] = hitless ? calB[calAdr] : 8'h00;
        `TCS_ADDR(`TCS_IDX_BURST): next_prdata[9:0] = burstReg;
        `TCS_ADDR(`TCS_IDX_SCHED): begin
          next_prdata[`TCS_CREDIT_W-1:0] = curCredit;
          next_prdata[16 +: `TCS_PORT_W] = txPort;
          next_prdata[24] = txEnable;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // control and calendar registers; software times the rewrites
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hitless <= 1'b0;
      statusDisableReq <= `TCS_DISREQ_RST;
      multA <= '0;
      multB <= '0;
      lenA <= '0;
      lenB <= '0;
      calAdr <= '0;
      burstReg <= `TCS_BURST_RST;
    end else if (wrEn) begin
      case (idx)
        `TCS_ADDR_W'(`TCS_IDX_CTRL): begin
          hitless <= pwdata[`TCS_CTRL_HITLESS];
          statusDisableReq <= pwdata[`TCS_CTRL_DISREQ];
        end
        `TCS_ADDR_W'(`TCS_IDX_MULT_A): multA <= pwdata[7:0];
        `TCS_ADDR_W'(`TCS_IDX_MULT_B): if (hitless) multB <= pwdata[7:0];
        `TCS_ADDR_W'(`TCS_IDX_LEN_A): lenA <= pwdata[9:0];
        `TCS_ADDR_W'(`TCS_IDX_LEN_B): if (hitless) lenB <= pwdata[9:0];
        `TCS_ADDR_W'(`TCS_IDX_CAL_ADR): calAdr <= pwdata[9:0];
        `TCS_ADDR_W'(`TCS_IDX_BURST): burstReg <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  // indirect calendar memories
  always_ff @(posedge clk_sys) begin
    if (wrEn && idx == `TCS_ADDR_W'(`TCS_IDX_DATA_A)) begin
      calA[calAdr] <= pwdata[7:0];
    end
    if (wrEn && hitless && idx == `TCS_ADDR_W'(`TCS_IDX_DATA_B)) begin
      calB[calAdr] <= pwdata[7:0];
    end
  end

  // active calendar follows the received select word
  always_comb begin
    next_activeSel = activeSel;
    if (!hitless) begin
      next_activeSel = 1'b0;
    end else if (calSelWord == `TCS_CALWORD_A) begin
      next_activeSel = 1'b0;
    end else if (calSelWord == `TCS_CALWORD_B) begin
      next_activeSel = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activeSel <= 1'b0;
      activeMultiplier <= '0;
      activeLength <= '0;
    end else begin
      activeSel <= next_activeSel;
      activeMultiplier <= next_activeSel ? multB : multA;
      activeLength <= next_activeSel ? lenB : lenA;
    end
  end

  // port selection and burst accounting
  always_comb begin
    logic found;
    logic [`TCS_PORT_W-1:0] cand;
    logic [`TCS_BURST_W:0] sent;
    logic [`TCS_CREDIT_W-1:0] cur;
    logic leave;
    found = 1'b0;
    cand = '0;
    sent = '0;
    cur = '0;
    leave = 1'b0;
    next_state = state;
    next_curCredit = curCredit;
    next_sentCount = sentCount;
    next_txPort = txPort;
    next_txEnable = txEnable;
    next_lastPort = lastPort;
    case (state)
      tcs_pkg::TCS_IDLE: begin
        // round robin from the port after the last one served
        for (int i = 0; i < `TCS_NPORTS; i++) begin
          cand = lastPort + `TCS_PORT_W'(i + 1);
          if (!found && nextCredit[cand] >= `TCS_CREDIT_W'(burstBytes) &&
              bufLevel[cand] >= `TCS_LEVEL_W'(burstBytes)) begin
            found = 1'b1;
            next_txPort = cand;
          end
        end
        if (found) begin
          next_curCredit = nextCredit[next_txPort];
          next_sentCount = '0;
          next_txEnable = 1'b1;
          next_state = tcs_pkg::TCS_SERVE;
        end
      end
      tcs_pkg::TCS_SERVE: begin
        if (beat.valid) begin
          sent = {1'b0, sentCount} + (`TCS_BURST_W+1)'(beat.bytes);
          cur = (curCredit > `TCS_CREDIT_W'(beat.bytes)) ?
                curCredit - `TCS_CREDIT_W'(beat.bytes) : '0;
          next_curCredit = cur;
          next_sentCount = sent[`TCS_BURST_W-1:0];
          if (sent >= {1'b0, burstBytes} || beat.eop) begin
            next_sentCount = '0;
            case (switchMode)
              `TCS_MODE_NOEOP: leave = cur < `TCS_CREDIT_W'(burstBytes) ||
                  bufLevel[txPort] < `TCS_LEVEL_W'(burstBytes);
              `TCS_MODE_EOP: leave = beat.eop || cur < `TCS_CREDIT_W'(burstBytes) ||
                  bufLevel[txPort] < `TCS_LEVEL_W'(burstBytes);
              default: leave = 1'b1;
            endcase
          end
          if (leave) begin
            next_txEnable = 1'b0;
            next_lastPort = txPort;
            next_state = tcs_pkg::TCS_IDLE;
          end
        end
      end
      default: begin
        next_txEnable = 1'b0;
        next_state = tcs_pkg::TCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= tcs_pkg::TCS_IDLE;
      curCredit <= '0;
      sentCount <= '0;
      txPort <= '0;
      txEnable <= 1'b0;
      lastPort <= '1;
    end else begin
      state <= next_state;
      curCredit <= next_curCredit;
      sentCount <= next_sentCount;
      txPort <= next_txPort;
      txEnable <= next_txEnable;
      lastPort <= next_lastPort;
    end
  end
endmodule
`default_nettype wire
